// [setpoint_stepper_defines.vh]
// Constants for the incremental setpoint stepper
`ifndef SETPOINT_STEPPER_DEFINES_VH
`define SETPOINT_STEPPER_DEFINES_VH

// Clock rate in kHz (25 MHz)
`define CLK_KHZ 25000
// Times in ms
`define QUAL_MS 64
`define RAMP_START_MS 2000
`define STEP_MS 282
`define SAVE_MS 2000
`define ACK_MS 500
`define BLINK_MS 141
// Cycle counts derived from the times (beyond times round up)
`define QUAL_CYC (`QUAL_MS * `CLK_KHZ)
`define RAMP_START_CYC (`RAMP_START_MS * `CLK_KHZ + 1)
`define STEP_CYC (`STEP_MS * `CLK_KHZ)
`define SAVE_CYC (`SAVE_MS * `CLK_KHZ)
`define ACK_CYC (`ACK_MS * `CLK_KHZ)
`define BLINK_CYC (`BLINK_MS * `CLK_KHZ)
// Milliseconds to cycles factor for the configured step interval
`define MS_CYC `CLK_KHZ

// Register byte addresses
`define REG_CTRL 12'h000
`define REG_STEPS 12'h004
`define REG_INTERVAL 12'h008
`define REG_LOWER 12'h00c
`define REG_UPPER 12'h010
`define REG_START 12'h014
`define REG_VALUE 12'h018
`define REG_STATUS 12'h01c

// Control fields
`define CTRL_ENDLESS 0
`define CTRL_LOAD 1

// Reset values
`define STEPS_RST 10'h100
`define INTERVAL_RST 11'h11a
`define LOWER_RST 10'h000
`define UPPER_RST 10'h100
`define START_RST 10'h000
`define STEPS_MIN 10'h002
`define STEPS_MAX 10'h3e8
`define INTERVAL_MIN 11'h00a
`define INTERVAL_MAX 11'h7d0

`endif

// [setpoint_stepper.v]
// Up/down setpoint stepper with ramp, store and indicator LEDs
// Function
// - Full range split into 256 equal steps by default.
// - Input held at least 64 ms counts as one pulse, one step.
// - Input held beyond 2000 ms steps automatically every 282 ms.
// - Optional endless ramp reverses direction at either range limit.
// - Front buttons step up and down like the direction inputs.
// - Both buttons held 2 s store setpoint as power-up start value.
// - Green power LED blanks briefly to acknowledge a store.
// - Red LED per direction input lit while that input is active.
// - During ramping the red LED of current direction flashes.
// - Step count 2..1000, interval 10..2000 ms, limits, mode, start set.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`include "setpoint_stepper_defines.vh"
`default_nettype none

module setpoint_stepper (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Direction inputs and front buttons, active high
   input wire dir_up,
   input wire dir_down,
   input wire key_up,
   input wire key_down,
   // Non-volatile start value store
   input wire [9:0] nv_value,
   output reg nv_write_q,
   output reg [9:0] nv_data_q,
   // Setpoint to the analog stage, and its full-scale count
   output reg [9:0] setpoint_q,
   output reg [9:0] full_scale_q,
   // Indicators
   output reg led_power_q,
   output reg led_up_q,
   output reg led_down_q
);

   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_HELD = 3'b010;
   localparam [2:0] S_RAMP = 3'b100;

   // Configuration registers
   reg endless_q;
   reg [9:0] steps_q;
   reg [10:0] interval_q;
   reg [9:0] lower_q;
   reg [9:0] upper_q;
   reg [9:0] start_q;
   reg loaded_q;

   // Stepping state
   reg [2:0] state_q;
   reg up_q;
   reg ramp_up_q;
   reg [26:0] hold_cnt_q;
   reg [26:0] step_cnt_q;
   reg [26:0] save_cnt_q;
   reg [26:0] ack_cnt_q;
   reg [26:0] blink_cnt_q;
   reg blink_q;
   reg saved_q;

   wire want_up = dir_up | key_up;
   wire want_down = dir_down | key_down;
   wire both_keys = key_up & key_down;
   wire one_dir = want_up ^ want_down;
   // A new direction while one is held restarts qualification from idle
   wire dir_flip = want_up != up_q;
   // Cycle counts are formed at 32 bits and cut to the counter width
   wire [31:0] step_prod = interval_q * `MS_CYC;
   wire [26:0] step_cyc = step_prod[26:0];
   wire [31:0] ack_cyc = `ACK_CYC;

   wire wr = psel & penable & pwrite;
   assign pready = 1'b1;
   wire bad_addr = paddr[1:0] != 2'b00 || paddr > `REG_STATUS;
   assign pslverr = psel & penable & bad_addr;

   // Status bits: store ack, ramping, ramp direction, busy, both keys
   wire st_ack = ~led_power_q;
   wire st_ramp = state_q == S_RAMP;
   wire st_busy = state_q != S_IDLE;
   wire [4:0] status = {st_ack, st_ramp, ramp_up_q, st_busy, both_keys};

   // Read mux
   reg [31:0] rd_mux;
   always @* begin
      case (paddr)
         `REG_CTRL: rd_mux = {31'h0, endless_q};
         `REG_STEPS: rd_mux = {22'h0, steps_q};
         `REG_INTERVAL: rd_mux = {21'h0, interval_q};
         `REG_LOWER: rd_mux = {22'h0, lower_q};
         `REG_UPPER: rd_mux = {22'h0, upper_q};
         `REG_START: rd_mux = {22'h0, start_q};
         `REG_VALUE: rd_mux = {22'h0, setpoint_q};
         `REG_STATUS: rd_mux = {27'h0, status};
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data is taken in the setup phase and stands through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // Configuration writes; step count and interval clamped to legal ranges
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         endless_q <= 1'b0;
         steps_q <= `STEPS_RST;
         interval_q <= `INTERVAL_RST;
         lower_q <= `LOWER_RST;
         upper_q <= `UPPER_RST;
         start_q <= `START_RST;
      end else if (wr) begin
         case (paddr)
            `REG_CTRL: endless_q <= pwdata[`CTRL_ENDLESS];
            `REG_STEPS: begin
               if (pwdata[31:10] != 22'h0) steps_q <= `STEPS_MAX;
               else if (pwdata[9:0] < `STEPS_MIN) steps_q <= `STEPS_MIN;
               else if (pwdata[9:0] > `STEPS_MAX) steps_q <= `STEPS_MAX;
               else steps_q <= pwdata[9:0];
            end
            `REG_INTERVAL: begin
               if (pwdata[31:11] != 21'h0) interval_q <= `INTERVAL_MAX;
               else if (pwdata[10:0] < `INTERVAL_MIN) interval_q <= `INTERVAL_MIN;
               else if (pwdata[10:0] > `INTERVAL_MAX) interval_q <= `INTERVAL_MAX;
               else interval_q <= pwdata[10:0];
            end
            `REG_LOWER: lower_q <= pwdata[9:0];
            `REG_UPPER: upper_q <= pwdata[9:0];
            `REG_START: start_q <= pwdata[9:0];
            default: ;
         endcase
      end
   end

   // Effective limits bounded by the step count
   wire [9:0] hi_lim = (upper_q > steps_q) ? steps_q : upper_q;
   wire [9:0] lo_lim = (lower_q > hi_lim) ? hi_lim : lower_q;
   wire at_hi = setpoint_q >= hi_lim;
   wire at_lo = setpoint_q <= lo_lim;
   // A loaded start value is held inside the limits at once
   wire [9:0] start_lim = (start_q > hi_lim) ? hi_lim :
      ((start_q < lo_lim) ? lo_lim : start_q);

   // One-step request and its direction
   reg do_step;
   reg step_up;
   reg [2:0] state_d;
   always @* begin
      do_step = 1'b0;
      step_up = up_q;
      state_d = state_q;
      case (state_q)
         S_IDLE: if (one_dir && !both_keys) state_d = S_HELD;
         // The pulse step fires once; holding on leads into the ramp
         S_HELD: begin
            if (!one_dir || both_keys || dir_flip) begin
               state_d = S_IDLE;
            end else if (hold_cnt_q == `QUAL_CYC - 1) begin
               do_step = 1'b1;
            end else if (hold_cnt_q == `RAMP_START_CYC - 1) begin
               state_d = S_RAMP;
            end
         end
         S_RAMP: begin
            step_up = ramp_up_q;
            if (!one_dir || both_keys || dir_flip) state_d = S_IDLE;
            else if (step_cnt_q >= step_cyc - 27'd1) do_step = 1'b1;
         end
         default: state_d = S_IDLE;
      endcase
   end

   // Stepping, ramp timing and endless reversal
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         up_q <= 1'b0;
         ramp_up_q <= 1'b0;
         hold_cnt_q <= 27'h0;
         step_cnt_q <= 27'h0;
         setpoint_q <= 10'h000;
         loaded_q <= 1'b0;
      end else begin
         state_q <= state_d;
         // First cycle out of reset takes the stored start value
         if (!loaded_q) begin
            setpoint_q <= (nv_value > `STEPS_RST) ? `STEPS_RST : nv_value;
            loaded_q <= 1'b1;
         end else if (wr && paddr == `REG_CTRL && pwdata[`CTRL_LOAD]) begin
            setpoint_q <= start_lim;
         end else if (do_step) begin
            // Endless ramp turns back at a limit instead of stopping
            if (step_up) begin
               if (!at_hi) setpoint_q <= setpoint_q + 10'h001;
               else if (endless_q && state_q == S_RAMP) begin
                  setpoint_q <= setpoint_q - 10'h001;
                  ramp_up_q <= 1'b0;
               end
            end else begin
               if (!at_lo) setpoint_q <= setpoint_q - 10'h001;
               else if (endless_q && state_q == S_RAMP) begin
                  setpoint_q <= setpoint_q + 10'h001;
                  ramp_up_q <= 1'b1;
               end
            end
         end else if (setpoint_q > hi_lim) begin
            // Limits moved by software pull the value back inside
            setpoint_q <= hi_lim;
         end else if (setpoint_q < lo_lim) begin
            setpoint_q <= lo_lim;
         end
         if (state_q == S_IDLE) begin
            up_q <= want_up;
            ramp_up_q <= want_up;
            hold_cnt_q <= 27'h0;
         end else if (state_q == S_HELD) begin
            hold_cnt_q <= hold_cnt_q + 27'd1;
         end
         if (state_q != S_RAMP || do_step) step_cnt_q <= 27'h0;
         else step_cnt_q <= step_cnt_q + 27'd1;
      end
   end

   // Store on both keys held, acknowledge by blanking the power LED
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         save_cnt_q <= 27'h0;
         saved_q <= 1'b0;
         nv_write_q <= 1'b0;
         nv_data_q <= 10'h000;
         ack_cnt_q <= 27'h0;
         led_power_q <= 1'b0;
      end else begin
         nv_write_q <= 1'b0;
         // One store per hold; releasing either key re-arms it
         if (!both_keys) begin
            save_cnt_q <= 27'h0;
            saved_q <= 1'b0;
         end else if (!saved_q) begin
            if (save_cnt_q == `SAVE_CYC - 1) begin
               nv_write_q <= 1'b1;
               nv_data_q <= setpoint_q;
               saved_q <= 1'b1;
               save_cnt_q <= 27'h0;
            end else begin
               save_cnt_q <= save_cnt_q + 27'd1;
            end
         end
         // Power LED stays dark while the acknowledge count runs
         if (nv_write_q) ack_cnt_q <= ack_cyc[26:0];
         else if (ack_cnt_q != 27'h0) ack_cnt_q <= ack_cnt_q - 27'd1;
         led_power_q <= loaded_q && ack_cnt_q == 27'h0 && !nv_write_q;
      end
   end

   // Direction LEDs: steady while active, flashing while ramping
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_cnt_q <= 27'h0;
         blink_q <= 1'b0;
         led_up_q <= 1'b0;
         led_down_q <= 1'b0;
         full_scale_q <= `STEPS_RST;
      end else begin
         full_scale_q <= steps_q;
         // Flash phase toggles while ramping and restarts lit
         if (state_q != S_RAMP) begin
            blink_cnt_q <= 27'h0;
            blink_q <= 1'b1;
         end else if (blink_cnt_q == `BLINK_CYC - 1) begin
            blink_cnt_q <= 27'h0;
            blink_q <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 27'd1;
         end
         // Follows the next state so a released input stops the flashing at once
         if (state_d == S_RAMP) begin
            led_up_q <= ramp_up_q & blink_q;
            led_down_q <= ~ramp_up_q & blink_q;
         end else begin
            led_up_q <= dir_up;
            led_down_q <= dir_down;
         end
      end
   end

endmodule // setpoint_stepper

`default_nettype wire

// [stepper_asserts.sv]
// Port checker for the setpoint stepper
`timescale 1ns/10ps
`default_nettype none
`include "setpoint_stepper_defines.vh"
module stepper_asserts (
   // APB
   input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   // Inputs and outputs
   input wire dir_up, dir_down, key_up, key_down,
   input wire nv_write_q, led_power_q, led_up_q, led_down_q,
   input wire [9:0] nv_data_q, setpoint_q, full_scale_q
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire bad = paddr > `REG_STATUS || paddr[1:0] != 2'h0;
   wire up_in = dir_up | key_up;
   wire down_in = dir_down | key_down;
   sequence acc;
      psel && penable;
   endsequence
   sequence steps_wr;
      acc ##0 (pwrite && paddr == `REG_STEPS && pwdata >= 32'h2 && pwdata <= 32'h3e8);
   endsequence
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_bad: assert property (acc |-> pslverr == bad) else $error("pslverr wrong");
   a_value_read: assert property (acc ##0 (!pwrite && paddr == `REG_VALUE) |->
      prdata == {22'h0, $past(setpoint_q)}) else $error("value read wrong");
   a_steps_take: assert property (steps_wr |=> ##1 full_scale_q == $past(pwdata[9:0], 2))
      else $error("steps not taken");
   a_scale_range: assert property (full_scale_q >= 10'h2 && full_scale_q <= 10'h3e8)
      else $error("steps out of range");
   a_setpoint_top: assert property ($stable(full_scale_q) [*2] |->
      setpoint_q <= full_scale_q) else $error("setpoint over range");
   a_led_idle: assert property (!up_in && !down_in |=> !led_up_q && !led_down_q)
      else $error("red led lit while idle");
   a_led_on: assert property ($rose(dir_up) && !key_up && !$past(key_up) && !down_in |=>
      led_up_q) else $error("up led not lit");
   a_store_data: assert property (nv_write_q |-> nv_data_q == $past(setpoint_q))
      else $error("stored value wrong");
   a_power_blank: assert property ($fell(led_power_q) |->
      $past(nv_write_q) || $past(nv_write_q, 2)) else $error("power led blanked without store");
endmodule // stepper_asserts
bind setpoint_stepper stepper_asserts u_stepper_asserts (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .dir_up, .dir_down, .key_up,
   .key_down, .nv_write_q, .led_power_q, .led_up_q, .led_down_q, .nv_data_q, .setpoint_q,
   .full_scale_q);
`default_nettype wire

// [contact_model.sv]
// Contacts and front buttons: up, down, key up, key down
`timescale 1ns/10ps
`default_nettype none
module contact_model (
   // Clock and requested contact states
   input wire logic pclk,
   input wire logic [3:0] press,
   // Contact lines
   output logic [3:0] lines
);
   // Contacts change only at a clock edge and hold as long as pressed
   always @(posedge pclk) lines <= press;
endmodule // contact_model
`default_nettype wire

// [setpoint_stepper_bench.sv]
// Self-checking bench for the setpoint stepper
`timescale 1ns/10ps
`default_nettype none
`include "setpoint_stepper_defines.vh"
module setpoint_stepper_bench;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [9:0] nv_value = 10'h0, r;
   logic [3:0] press = 4'h0;
   wire [3:0] lines;
   wire [31:0] prdata;
   wire pready, pslverr, nv_write_q, led_power_q, led_up_q, led_down_q;
   wire [9:0] nv_data_q, setpoint_q, full_scale_q;
   logic [32:0] expq [$];
   logic [32:0] rst [0:5] = '{33'h0, 33'h100, 33'h11a, 33'h0, 33'h100, 33'h0};
   integer error_cnt = 0, checked = 0, seed = 32'h8c0a, i;
   setpoint_stepper u_setpoint_stepper (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dir_up(lines[0]), .dir_down(lines[1]),
      .key_up(lines[2]), .key_down(lines[3]), .nv_value(nv_value), .nv_write_q(nv_write_q),
      .nv_data_q(nv_data_q), .setpoint_q(setpoint_q), .full_scale_q(full_scale_q),
      .led_power_q(led_power_q), .led_up_q(led_up_q), .led_down_q(led_down_q));
   contact_model u_contact_model (.pclk(pclk), .press(press), .lines(lines));
   task chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One APB transfer; a read notes its expected error bit and data
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      integer n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) expq.push_back(e);
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n = n + 1;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         error_cnt = error_cnt + 1;
         test_done;
      end else begin
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 33'h0);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'h0, a, 32'h0, e);
   endtask
   // Completed reads are compared against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1 && !pwrite) begin
         chk("apb read", {pslverr, prdata}, expq.pop_front());
      end
   end
   initial forever #20 pclk = ~pclk;
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial begin
      nv_value <= 10'($random(seed)) & 10'h0ff;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
      rd(`REG_VALUE, {23'h0, nv_value});
      chk("power led", led_power_q, 33'h1);
      chk("full scale", full_scale_q, 33'h100);
      for (i = 0; i < 6; i = i + 1) rd(12'(i * 4), rst[i]);
      rd(12'h020, 33'h100000000);
      wr(12'h006, 32'h5);
      rd(12'h006, 33'h100000000);
      rd(`REG_STEPS, 33'h100);
      r = 10'h2 + 10'($unsigned($random(seed)) % 999);
      wr(`REG_STEPS, 32'h1);
      rd(`REG_STEPS, 33'h2);
      wr(`REG_STEPS, 32'h7d0);
      rd(`REG_STEPS, 33'h3e8);
      wr(`REG_STEPS, {22'h0, r});
      rd(`REG_STEPS, {23'h0, r});
      wr(`REG_STEPS, 32'h64);
      rd(`REG_VALUE, (nv_value > 10'h2) ? 33'h2 : {23'h0, nv_value});
      wr(`REG_LOWER, 32'h28);
      wr(`REG_START, 32'h0a);
      wr(`REG_CTRL, 32'h2);
      rd(`REG_VALUE, 33'h28);
      wr(`REG_START, 32'h46);
      wr(`REG_CTRL, 32'h3);
      rd(`REG_CTRL, 33'h1);
      rd(`REG_VALUE, 33'h46);
      wr(`REG_INTERVAL, 32'h5);
      rd(`REG_INTERVAL, 33'h0a);
      wr(`REG_INTERVAL, 32'hbb8);
      rd(`REG_INTERVAL, 33'h7d0);
      for (i = 0; i < 2; i = i + 1) begin
         press <= 4'(1 << i);
         repeat (4) @(posedge pclk);
         chk("up led", led_up_q, 33'(i == 0));
         chk("down led", led_down_q, 33'(i == 1));
         rd(`REG_STATUS, (i == 0) ? 33'h6 : 33'h2);
         press <= 4'h0;
         repeat (4) @(posedge pclk);
      end
      press <= 4'hc;
      repeat (40) @(posedge pclk);
      rd(`REG_VALUE, 33'h46);
      press <= 4'h0;
      repeat (4) @(posedge pclk);
      test_done;
   end
endmodule // setpoint_stepper_bench
`default_nettype wire
